// *** verilog/scx_channel.sv ***
// Serial channel: async 7/8/9-bit and clocked shift mode, double-buffered rx.
// Assumes pins are asynchronous to clk_i; registers reached by a strobe port.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module scx_channel #(
  parameter int unsigned BASE_DIV = 4
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire scx_pkg::scx_bus_req_t bus_i,
  output logic [scx_pkg::DATA_W-1:0] bus_rdata_o,
  input  wire logic                 rx_data_pin_i,
  output logic                      tx_data_pin_o,
  input  wire logic                 shift_clock_pin_i,
  output logic                      shift_clock_pin_o,
  output logic                      shift_clock_pin_oe_o,
  input  wire logic                 clear_to_send_n_i,
  output logic                      receive_done_irq_o,
  output logic                      transmit_empty_irq_o
);
  logic [7:0]              mode_reg, cfg_reg, div_reg, tx_buf_reg, rx_buf_reg;
  logic [2:0]              pins_s;
  logic                    rx_s, sclk_s, cts_n_s, sclk_prev_reg, base_tick;
  scx_pkg::scx_mode_t      mode;
  logic                    is_shift, pe, even, dir_in, cts_ok, long_frame;
  logic [3:0]              nbits, tx_cnt_reg, tx_left_reg, sh_cnt_reg, smp_reg, idx_reg;
  logic                    tick_rise, tick_fall, tx_full_reg, tx_busy_reg, tx_waited_reg;
  logic [10:0]             tx_sr_reg, frame;
  logic [8:0]              data9, rx1_reg, xfer_data;
  logic                    tx_start, tx_shift_async, tx_done_evt, tx_irq_reg;
  logic                    sh_run_reg, sh_rx_reg, sclk_out_reg, sh_start, shift_edge, sh_done;
  scx_pkg::scx_rx_state_t  rx_state_reg;
  logic [1:0]              vote_reg;
  logic                    rx_bit, rx_decide, last_evt, stop_evt, drop_reg;
  logic                    ovr_evt, parity_error_flag_evt, xfer_async, xfer_shift, rx_irq_evt;
  logic                    rx_full_reg, rb8_reg, rx_irq_reg;
  scx_pkg::scx_err_t       err_reg;
  logic                    wr_mode, wr_ctrl, wr_buf, rd_ctrl, rd_buf;

  function automatic logic par_of(input logic [7:0] d, input logic ev);
    return (^d) ^ ~ev;
  endfunction

  scx_sync #(.WIDTH(3), .RESET_VAL(3'h7)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({rx_data_pin_i, shift_clock_pin_i, clear_to_send_n_i}),
    .sync_o  (pins_s)
  );
  assign rx_s    = pins_s[2];
  assign sclk_s  = pins_s[1];
  assign cts_n_s = pins_s[0];

  // register port decode
  assign wr_mode = bus_i.wr & (bus_i.addr == scx_pkg::REG_MODE);
  assign wr_ctrl = bus_i.wr & (bus_i.addr == scx_pkg::REG_CTRL);
  assign wr_buf  = bus_i.wr & (bus_i.addr == scx_pkg::REG_BUF);
  assign rd_ctrl = bus_i.rd & (bus_i.addr == scx_pkg::REG_CTRL);
  assign rd_buf  = bus_i.rd & (bus_i.addr == scx_pkg::REG_BUF);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg <= scx_pkg::MODE_RST;
      cfg_reg  <= scx_pkg::CFG_RST;
    end else begin
      if (wr_mode) begin
        mode_reg <= bus_i.wdata;
      end
      if (wr_ctrl) begin
        cfg_reg <= bus_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_rdata_o <= 8'h00;
    end else if (bus_i.rd) begin
      unique case (bus_i.addr)
        scx_pkg::REG_MODE: bus_rdata_o <= mode_reg;
        scx_pkg::REG_CTRL: bus_rdata_o <= {rb8_reg, cfg_reg[scx_pkg::CTRL_EVEN],
                                           cfg_reg[scx_pkg::CTRL_PE], err_reg,
                                           cfg_reg[scx_pkg::CTRL_CLOCK_EDGE_SELECT:scx_pkg::CTRL_IOC]};
        scx_pkg::REG_BUF:  bus_rdata_o <= rx_buf_reg;
        scx_pkg::REG_STAT: bus_rdata_o <= {5'h00, rx_full_reg, tx_busy_reg, tx_full_reg};
      endcase
    end else begin
      bus_rdata_o <= 8'h00;
    end
  end

  // configuration decode
  assign mode   = scx_pkg::scx_mode_t'(mode_reg[scx_pkg::MODE_SM_MSB:scx_pkg::MODE_SM_LSB]); // R26
  assign is_shift = (mode == scx_pkg::SCX_MODE_SHIFT);
  assign pe     = cfg_reg[scx_pkg::CTRL_PE] &
                  ((mode == scx_pkg::SCX_MODE_7) | (mode == scx_pkg::SCX_MODE_8));
  assign even   = cfg_reg[scx_pkg::CTRL_EVEN];
  assign dir_in = cfg_reg[scx_pkg::CTRL_IOC];
  assign long_frame = (mode == scx_pkg::SCX_MODE_9) | ((mode == scx_pkg::SCX_MODE_8) & pe);
  assign cts_ok = ~mode_reg[scx_pkg::MODE_CLEAR_TO_SEND_ENABLE] | ~cts_n_s; // R08

  always_comb begin
    unique case (mode)
      scx_pkg::SCX_MODE_SHIFT: nbits = scx_pkg::BITS8;
      scx_pkg::SCX_MODE_7:     nbits = scx_pkg::BITS7 + {3'h0, pe};
      scx_pkg::SCX_MODE_8:     nbits = scx_pkg::BITS8 + {3'h0, pe};
      scx_pkg::SCX_MODE_9:     nbits = scx_pkg::BITS9;
    endcase
  end

  // channel base clock stand-in: one enable pulse every BASE_DIV cycles
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg <= 8'h00;
    end else if (base_tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
  assign base_tick = (div_reg == 8'(BASE_DIV - 1));

  // transmit bit-tick: high half of the 4-bit count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_cnt_reg <= 4'h0;
    end else if (base_tick & ~is_shift) begin
      tx_cnt_reg <= tx_cnt_reg + 4'h1; // R04
    end
  end
  assign tick_rise = base_tick & ~is_shift & (tx_cnt_reg == scx_pkg::TICK_HALF);
  assign tick_fall = base_tick & ~is_shift & (tx_cnt_reg == scx_pkg::TICK_LAST);

  // frame image: start bit at 0, data lsb first, stop ones above
  always_comb begin
    data9 = {mode_reg[scx_pkg::MODE_TB8], tx_buf_reg};
    if (pe & (mode == scx_pkg::SCX_MODE_7)) begin
      data9[7] = par_of({1'b0, tx_buf_reg[6:0]}, even); // R14
    end
    if (pe & (mode == scx_pkg::SCX_MODE_8)) begin
      data9[8] = par_of(tx_buf_reg, even); // R14
    end
    frame = {1'b1, data9, 1'b0} | (scx_pkg::FRAME_IDLE << (nbits + 4'h1));
  end

  // cts only gates the start of a character, never one in flight
  assign tx_start = ~is_shift & tx_full_reg & ~tx_busy_reg & cts_ok &
                    (tx_waited_reg ? tick_fall : tick_rise); // R07 R09 R10
  assign tx_shift_async = ~is_shift & tx_busy_reg & tick_rise & (tx_left_reg != 4'h0);
  assign tx_done_evt = (tx_shift_async & (tx_left_reg == 4'h1)) |
                       (sh_done & tx_busy_reg); // R20 R21

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_buf_reg  <= 8'h00;
      tx_full_reg <= 1'b0;
    end else begin
      if (tx_done_evt) begin
        tx_full_reg <= 1'b0; // R13
      end
      if (wr_buf & ~tx_full_reg) begin
        tx_buf_reg  <= bus_i.wdata; // R13
        tx_full_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_waited_reg <= 1'b0;
    end else if (tx_start | is_shift) begin
      tx_waited_reg <= 1'b0;
    end else if (tx_full_reg & ~tx_busy_reg & ~cts_ok) begin
      tx_waited_reg <= 1'b1; // R10
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_busy_reg   <= 1'b0; // R27
      tx_sr_reg     <= scx_pkg::FRAME_IDLE;
      tx_left_reg   <= 4'h0;
      tx_data_pin_o <= 1'b1;
    end else if (tx_start) begin
      tx_busy_reg   <= 1'b1;
      tx_data_pin_o <= frame[0];
      tx_sr_reg     <= {1'b1, frame[10:1]};
      tx_left_reg   <= nbits + 4'h1;
    end else if (tx_shift_async | (shift_edge & tx_busy_reg)) begin
      tx_data_pin_o <= tx_sr_reg[0]; // R05 R06 R12
      tx_sr_reg     <= {1'b1, tx_sr_reg[10:1]};
      tx_left_reg   <= tx_left_reg - 4'h1;
      if (sh_done) begin
        tx_busy_reg <= 1'b0;
      end
    end else if (~is_shift & tx_busy_reg & tick_rise) begin
      tx_busy_reg <= 1'b0;
    end else if (sh_start & tx_full_reg) begin
      tx_busy_reg <= 1'b1;
      tx_sr_reg   <= {3'h7, tx_buf_reg};
      tx_left_reg <= scx_pkg::BITS8;
    end
  end

  // shift mode burst of eight clock cycles
  assign sh_start = is_shift & ~sh_run_reg &
                    (tx_full_reg | (mode_reg[scx_pkg::MODE_RXE] & ~rx_full_reg));
  // gated by mode so a burst left over from shift mode cannot shift async data
  assign shift_edge = is_shift & sh_run_reg & (dir_in ?
                      (cfg_reg[scx_pkg::CTRL_CLOCK_EDGE_SELECT] ? (~sclk_s & sclk_prev_reg)
                                                    : (sclk_s & ~sclk_prev_reg))
                      : (base_tick & ~sclk_out_reg)); // R05 R06
  assign sh_done = shift_edge & (sh_cnt_reg == scx_pkg::SHIFT_LAST);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_run_reg    <= 1'b0;
      sh_rx_reg     <= 1'b0;
      sh_cnt_reg    <= 4'h0;
      sclk_out_reg  <= 1'b1;
      sclk_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_s;
      if (~is_shift) begin
        sh_run_reg <= 1'b0;
      end else if (sh_start) begin
        sh_run_reg <= 1'b1;
        sh_rx_reg  <= mode_reg[scx_pkg::MODE_RXE] & ~rx_full_reg;
        sh_cnt_reg <= 4'h0;
      end else if (shift_edge) begin
        sh_cnt_reg <= sh_cnt_reg + 4'h1;
        if (sh_done) begin
          sh_run_reg <= 1'b0;
        end
      end
      // output clock idles high, so the edge that ends a burst is a rising one
      if (sh_run_reg & ~dir_in & base_tick) begin
        sclk_out_reg <= ~sclk_out_reg;
      end else if (~sh_run_reg) begin
        sclk_out_reg <= 1'b1;
      end
    end
  end
  assign shift_clock_pin_o    = sclk_out_reg;
  assign shift_clock_pin_oe_o = is_shift & ~dir_in;

  // async receiver: 16 base clocks per bit, vote on the 7th to 9th
  assign rx_bit = (vote_reg[1] & vote_reg[0]) | (vote_reg[1] & rx_s) |
                  (vote_reg[0] & rx_s); // R24
  assign rx_decide = base_tick & ~is_shift & (rx_state_reg != scx_pkg::SCX_RX_IDLE) &
                     (smp_reg == scx_pkg::SMP_LAST);
  assign last_evt = rx_decide & (rx_state_reg == scx_pkg::SCX_RX_DATA) &
                    (idx_reg == nbits - 4'h1);
  assign stop_evt = rx_decide & (rx_state_reg == scx_pkg::SCX_RX_STOP);
  assign ovr_evt  = rx_full_reg & ((last_evt & long_frame) | (stop_evt & ~long_frame)); // R19
  assign parity_error_flag_evt = last_evt & pe & (rx_bit != par_of((mode == scx_pkg::SCX_MODE_7) ?
                    {1'b0, rx1_reg[6:0]} : rx1_reg[7:0], even)); // R16 R19
  assign xfer_async = stop_evt & ~drop_reg & ~ovr_evt; // R01
  assign xfer_shift = sh_done & sh_rx_reg & ~rx_full_reg;
  assign xfer_data  = is_shift ? {1'b0, rx_s, rx1_reg[6:0]} : rx1_reg;
  assign rx_irq_evt = xfer_shift | (xfer_async & ~((mode == scx_pkg::SCX_MODE_9) &
                      mode_reg[scx_pkg::MODE_WU] & ~rx1_reg[8])); // R03 R22 R25

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state_reg <= scx_pkg::SCX_RX_IDLE;
      smp_reg      <= 4'h0;
      vote_reg     <= 2'h3;
      idx_reg      <= 4'h0;
      rx1_reg      <= 9'h000;
      drop_reg     <= 1'b0;
    end else if (is_shift) begin
      rx_state_reg <= scx_pkg::SCX_RX_IDLE;
      if (shift_edge & sh_rx_reg) begin
        rx1_reg[sh_cnt_reg[2:0]] <= rx_s;
      end
    end else if (~mode_reg[scx_pkg::MODE_RXE]) begin
      rx_state_reg <= scx_pkg::SCX_RX_IDLE;
    end else if (base_tick) begin
      smp_reg <= smp_reg + 4'h1;
      if ((smp_reg == scx_pkg::SMP_FIRST) | (smp_reg == scx_pkg::SMP_MID)) begin
        vote_reg <= {vote_reg[0], rx_s};
      end
      unique case (rx_state_reg)
        scx_pkg::SCX_RX_IDLE: begin
          smp_reg <= 4'h0;
          if (~rx_s) begin
            rx_state_reg <= scx_pkg::SCX_RX_START;
          end
        end
        scx_pkg::SCX_RX_START: begin
          if (rx_decide) begin
            rx_state_reg <= rx_bit ? scx_pkg::SCX_RX_IDLE : scx_pkg::SCX_RX_DATA;
            idx_reg      <= 4'h0;
            rx1_reg      <= 9'h000;
            drop_reg     <= 1'b0;
          end
        end
        scx_pkg::SCX_RX_DATA: begin
          if (rx_decide) begin
            rx1_reg[idx_reg] <= rx_bit;
            idx_reg          <= idx_reg + 4'h1;
            if (last_evt) begin
              rx_state_reg <= scx_pkg::SCX_RX_STOP;
              drop_reg     <= ovr_evt; // R01
            end
          end
        end
        scx_pkg::SCX_RX_STOP: begin
          if (rx_decide) begin
            rx_state_reg <= scx_pkg::SCX_RX_IDLE; // R18
          end
        end
      endcase
    end
  end

  // stage two: a transfer in the same cycle as a read keeps the buffer full
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_buf_reg  <= 8'h00;
      rb8_reg     <= 1'b0;
      rx_full_reg <= 1'b0;
    end else begin
      if (rd_buf) begin
        rx_full_reg <= 1'b0;
      end
      if (xfer_async | xfer_shift) begin
        rx_buf_reg  <= xfer_data[7:0];
        rb8_reg     <= xfer_data[8]; // R02
        rx_full_reg <= 1'b1; // R25
      end
    end
  end

  // error flags sticky until control register read; a new error wins the clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_reg <= '0;
    end else begin
      if (rd_ctrl) begin
        err_reg <= '0;
      end
      if (ovr_evt) begin
        err_reg.overrun_error_flag <= 1'b1; // R01 R18
      end
      if (parity_error_flag_evt) begin
        err_reg.parity_error_flag <= 1'b1; // R16 R18
      end
      if (stop_evt & ~rx_bit) begin
        err_reg.framing_error_flag <= 1'b1; // R17 R19
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_irq_reg <= 1'b0;
      tx_irq_reg <= 1'b0;
    end else begin
      rx_irq_reg <= rx_irq_evt; // R19 R22
      tx_irq_reg <= tx_done_evt; // R13 R20 R21
    end
  end
  assign receive_done_irq_o   = rx_irq_reg;
  assign transmit_empty_irq_o = tx_irq_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_tick_spacing: assert property (tick_rise |=> (~tick_rise)[*8]) // R04
    else $error("bit-tick rising edges too close");
  a_start_bit_low: assert property (tx_start |=> ~tx_data_pin_o && tx_busy_reg) // R07
    else $error("async start did not drive start bit");
  a_cts_gate: assert property (tx_start && mode_reg[scx_pkg::MODE_CLEAR_TO_SEND_ENABLE] |-> ~cts_n_s) // R08
    else $error("character started while clear-to-send high");
  a_buf_write_ignored: assert property (wr_buf && tx_full_reg |=> $stable(tx_buf_reg)) // R13
    else $error("transmit buffer overwritten while full");
  a_overrun_keeps: assert property ($rose(err_reg.overrun_error_flag) |-> $stable(rx_buf_reg) && $stable(rb8_reg)) // R01
    else $error("overrun disturbed stage two");
  a_stop_after_irq: assert property (tx_done_evt && ~is_shift |=> tx_data_pin_o) // R20
    else $error("transmit interrupt not ahead of stop bit");
  a_wakeup_filter: assert property (receive_done_irq_o && ~is_shift && mode == scx_pkg::SCX_MODE_9
                                    && mode_reg[scx_pkg::MODE_WU] |-> rb8_reg) // R03
    else $error("wake-up interrupt on data character");
  a_flags_sticky: assert property (err_reg.framing_error_flag && ~rd_ctrl |=> err_reg.framing_error_flag) // R18
    else $error("framing flag lost before read");
  a_shift_irq_timing: assert property (sh_done && tx_busy_reg |=> ##0 transmit_empty_irq_o
                                       && ~tx_busy_reg) // R21
    else $error("shift transmit interrupt not after last edge");
  a_rx_full_irq: assert property (receive_done_irq_o |-> rx_full_reg) // R25
    else $error("receive interrupt without stage two full");

  c_async_rx: cover property (receive_done_irq_o && ~is_shift);
  c_async_tx: cover property (transmit_empty_irq_o && ~is_shift);
  c_overrun:  cover property ($rose(err_reg.overrun_error_flag));
  c_shift_rx: cover property (xfer_shift);
endmodule

// *** verilog/scx_pkg.sv ***
// Constants, field positions and carrier types for the serial channel.
// Assumes a single clk_i domain; the register port is a plain strobe port.
// Functional notes
// R01 - Stage one keeps receiving; overrun sets flag, drops new char, keeps stage two.
// R02 - Received bit eight holds parity (8-bit) or address/data flag (9-bit).
// R03 - 9-bit with wake-up: receive interrupt only when received bit eight is 1.
// R04 - Async: 4-bit counter gives one transmit bit-tick per 16 base clocks.
// R05 - Shift mode, clock output: data bit placed at driven rising clock edge.
// R06 - Shift mode, clock input: data shifted on edge chosen by edge select.
// R07 - Async: transmission starts at next bit-tick rising edge after buffer write.
// R08 - With clear-to-send checking on, start a character only while input low.
// R09 - Clear-to-send rising mid character: finish it, then hold until low again.
// R10 - Loaded while blocked: stay idle, then start at first bit-tick falling edge.
// R11 - Remote receiver raises its request-to-send in its receive interrupt handler.
// R12 - Character shifted out least significant bit first, one bit per shift clock.
// R13 - Transmit-empty interrupt when buffer frees; writes during shifting are ignored.
// R14 - Parity generated even or odd into bit seven (7-bit) or eight (8-bit).
// R15 - Software sets parity enable and polarity before writing the transmit buffer.
// R16 - On transfer to stage two, check parity bit seven or eight; flag mismatch.
// R17 - Framing error when stop bit votes 0; votes use middle three samples.
// R18 - Errors do not stop reception; error flags stay set until read.
// R19 - Async receive event timing: interrupt, framing, parity and overrun points.
// R20 - Async transmit interrupt just before the stop bit goes out.
// R21 - Shift mode transmit interrupt follows the last clock edge.
// R22 - Shift mode receive interrupt when character reaches stage two.
// R23 - Software leaves control settings and receive enable alone mid transfer.
// R24 - Each async bit spans 16 base clocks; 2-of-3 vote on clocks 7 to 9.
// R25 - Full character in stage one moves to stage two with receive interrupt.
// R26 - Mode field: 00 shift, 01 7-bit, 10 8-bit, 11 9-bit asynchronous.
// R27 - Reset: data line high, flags and both stages clear, transmitter idle empty.
package scx_pkg;
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] REG_MODE = 2'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL = 2'h1;
  localparam logic [ADDR_W-1:0] REG_BUF  = 2'h2;
  localparam logic [ADDR_W-1:0] REG_STAT = 2'h3;

  // channel_mode_reg fields
  localparam int unsigned MODE_TB8    = 7;
  localparam int unsigned MODE_CLEAR_TO_SEND_ENABLE   = 6;
  localparam int unsigned MODE_RXE    = 5;
  localparam int unsigned MODE_WU     = 4;
  localparam int unsigned MODE_SM_MSB = 3;
  localparam int unsigned MODE_SM_LSB = 2;
  // channel_control_reg fields
  localparam int unsigned CTRL_RB8    = 7;
  localparam int unsigned CTRL_EVEN   = 6;
  localparam int unsigned CTRL_PE     = 5;
  localparam int unsigned CTRL_OVERRUN_ERROR_FLAG   = 4;
  localparam int unsigned CTRL_PARITY_ERROR_FLAG   = 3;
  localparam int unsigned CTRL_FRAMING_ERROR_FLAG   = 2;
  localparam int unsigned CTRL_CLOCK_EDGE_SELECT  = 1;
  localparam int unsigned CTRL_IOC    = 0;
  // status register fields
  localparam int unsigned STAT_TXFULL = 0;
  localparam int unsigned STAT_TXBUSY = 1;
  localparam int unsigned STAT_RXFULL = 2;

  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [7:0]  CFG_RST    = 8'h00;
  localparam logic [10:0] FRAME_IDLE = 11'h7FF;

  localparam logic [3:0] TICK_HALF  = 4'h7;
  localparam logic [3:0] TICK_LAST  = 4'hF;
  localparam logic [3:0] SMP_FIRST  = 4'h6;
  localparam logic [3:0] SMP_MID    = 4'h7;
  localparam logic [3:0] SMP_LAST   = 4'h8;
  localparam logic [3:0] SHIFT_LAST = 4'h7;
  localparam logic [3:0] BITS7      = 4'h7;
  localparam logic [3:0] BITS8      = 4'h8;
  localparam logic [3:0] BITS9      = 4'h9;

  typedef enum logic [1:0] {
    SCX_MODE_SHIFT = 2'b00,
    SCX_MODE_7     = 2'b01,
    SCX_MODE_8     = 2'b10,
    SCX_MODE_9     = 2'b11
  } scx_mode_t;

  typedef enum logic [1:0] {
    SCX_RX_IDLE  = 2'b00,
    SCX_RX_START = 2'b01,
    SCX_RX_DATA  = 2'b10,
    SCX_RX_STOP  = 2'b11
  } scx_rx_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } scx_bus_req_t;

  typedef struct packed {
    logic overrun_error_flag;
    logic parity_error_flag;
    logic framing_error_flag;
  } scx_err_t;
endpackage

// *** verilog/scx_sync.sv ***
// Two-stage synchroniser for pins arriving from outside the clk_i domain.
// Assumes the inputs are quasi-static compared to the 8 ns clock.
`timescale 1ns/1ps
module scx_sync #(
  parameter int unsigned       WIDTH     = 1,
  parameter logic [WIDTH-1:0]  RESET_VAL = '1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= RESET_VAL;
      sync_o   <= RESET_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule

// *** sim/scx_station.sv ***
// Remote station model: async frames on both lines and an external shift clock.
// Assumes the bench sets the bit period to 16 base ticks and the char length.
`timescale 1ns/1ps
module scx_station #(
  parameter realtime BIT_NS = 128
) (
  input  wire logic       tx_line_i,
  input  wire logic [3:0] nbits_i,
  output logic            rx_line_o,
  output logic            sclk_o,
  output logic            cts_n_o,
  output logic [8:0]      got_o,
  output logic            got_stb_o
);
  initial begin
    rx_line_o = 1'b1;
    sclk_o    = 1'b1;
    cts_n_o   = 1'b0;
    got_o     = 9'h000;
    got_stb_o = 1'b0;
  end
  // frame goes out lsb first, start bit in f[0]
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rx_line_o = f[i];
      #(BIT_NS);
    end
    rx_line_o = 1'b1;
  endtask
  // data changes while low so it is settled at the rising edge
  task automatic shift_in(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      sclk_o    = 1'b0;
      rx_line_o = d[i];
      #40;
      sclk_o = 1'b1;
      #40;
    end
    rx_line_o = 1'b1;
  endtask
  always @(negedge tx_line_i) begin
    #(BIT_NS / 2);
    if (!tx_line_i) begin
      got_o = 9'h000;
      for (int i = 0; i < nbits_i; i++) begin
        #(BIT_NS);
        got_o[i] = tx_line_i;
      end
      #(BIT_NS);
      // a bad stop bit gives no strobe, so the char goes missing
      got_stb_o = tx_line_i;
      #1 got_stb_o = 1'b0;
    end
  end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the serial channel against a remote station model.
// Assumes BASE_DIV of 1, so one async bit lasts 16 clocks.
`timescale 1ns/1ps
module tb_top;
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  scx_pkg::scx_bus_req_t bus = '0;
  logic [7:0]            rdata, d, d2;
  logic                  tx, sclk_o, sclk_oe, rx_irq, tx_irq, rx_line, sclk, cts_n, stb;
  logic [8:0]            got;
  logic [3:0]            nbits = 4'h8;
  logic                  rd_q = 1'b0;
  logic [15:0]           rq[$];
  logic [8:0]            cq[$];
  int                    fails = 0, checks = 0, rx_irqs = 0, tx_irqs = 0, k;
  always #4 clk_i = ~clk_i;
  scx_channel #(.BASE_DIV(1)) dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus),
    .bus_rdata_o(rdata), .rx_data_pin_i(rx_line), .tx_data_pin_o(tx),
    .shift_clock_pin_i(sclk_oe ? sclk_o : sclk), .shift_clock_pin_o(sclk_o),
    .shift_clock_pin_oe_o(sclk_oe), .clear_to_send_n_i(cts_n),
    .receive_done_irq_o(rx_irq), .transmit_empty_irq_o(tx_irq));
  scx_station st (.tx_line_i(tx), .nbits_i(nbits), .rx_line_o(rx_line), .sclk_o(sclk),
    .cts_n_o(cts_n), .got_o(got), .got_stb_o(stb));
  task automatic chk_reg(input string n, input logic [7:0] e, m, g);
    checks++;
    if ((g & m) !== (e & m)) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e & m, g & m);
    end
  endtask
  task automatic chk_char(input logic [8:0] e, g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value line char expected %h seen %h", e, g);
    end
  endtask
  always @(posedge clk_i) begin
    rd_q <= bus.rd;
    if (rx_irq === 1'b1) rx_irqs++;
    if (tx_irq === 1'b1) tx_irqs++;
    if (rd_q) begin
      chk_reg("read data", rq[0][15:8], rq[0][7:0], rdata);
      void'(rq.pop_front());
    end
  end
  // a char nobody expected can never match
  always @(posedge stb) chk_char(cq.size() != 0 ? cq.pop_front() : ~got, got);
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus <= '0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e, m);
    rq.push_back({e, m});
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus <= '0;
  endtask
  task automatic wait_tx();
    for (int i = 0; i < 3000 && cq.size() != 0; i++) @(posedge clk_i);
    repeat (16) @(posedge clk_i);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hADF5));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_reg("tx idle", 8'h01, 8'h01, {7'h00, tx});
    rd(scx_pkg::REG_STAT, 8'h00, 8'h07);
    d = 8'($urandom);
    wr(scx_pkg::REG_CTRL, 8'h01);
    wr(scx_pkg::REG_MODE, 8'h20);
    st.shift_in(d);
    repeat (8) @(posedge clk_i);
    chk_reg("shift rx irqs", 8'h01, 8'hFF, 8'(rx_irqs));
    rd(scx_pkg::REG_BUF, d, 8'hFF);
    wr(scx_pkg::REG_CTRL, 8'h60);
    for (int m = 1; m < 4; m++) begin
      d = 8'($urandom);
      nbits = (m == 1) ? 4'h8 : 4'h9;
      cq.push_back(m == 1 ? {1'b0, ^d[6:0], d[6:0]} : m == 2 ? {^d, d} : {1'b1, d});
      wr(scx_pkg::REG_MODE, {m == 3, 3'h0, m[1:0], 2'h0});
      wr(scx_pkg::REG_BUF, d);
      wr(scx_pkg::REG_BUF, ~d);
      wait_tx();
    end
    repeat (300) @(posedge clk_i);
    chk_reg("tx irqs", 8'h03, 8'hFF, 8'(tx_irqs));
    nbits = 4'h8;
    st.cts_n_o = 1'b1;
    wr(scx_pkg::REG_CTRL, 8'h00);
    wr(scx_pkg::REG_MODE, 8'h48);
    d = 8'($urandom);
    cq.push_back({1'b0, d});
    wr(scx_pkg::REG_BUF, d);
    repeat (600) @(posedge clk_i);
    chk_reg("held chars", 8'h01, 8'hFF, 8'(cq.size()));
    st.cts_n_o = 1'b0;
    wait_tx();
    chk_reg("held chars", 8'h00, 8'hFF, 8'(cq.size()));
    wr(scx_pkg::REG_MODE, 8'h28);
    d = 8'($urandom);
    d2 = 8'($urandom);
    st.send({2'b11, d, 1'b0}, 10);
    st.send({2'b11, d2, 1'b0}, 10);
    rd(scx_pkg::REG_CTRL, 8'h10, 8'h1C);
    rd(scx_pkg::REG_BUF, d, 8'hFF);
    rd(scx_pkg::REG_CTRL, 8'h00, 8'h1C);
    // short low stop bit so its tail cannot pass for a new start bit
    st.send({d2, 1'b0}, 9);
    st.rx_line_o = 1'b0;
    #88;
    st.rx_line_o = 1'b1;
    rd(scx_pkg::REG_CTRL, 8'h04, 8'h04);
    rd(scx_pkg::REG_BUF, d2, 8'hFF);
    wr(scx_pkg::REG_CTRL, 8'h60);
    st.send({1'b1, ~^d, d, 1'b0}, 11);
    rd(scx_pkg::REG_CTRL, {~^d, 7'h08}, 8'h88);
    rd(scx_pkg::REG_BUF, d, 8'hFF);
    wr(scx_pkg::REG_CTRL, 8'h00);
    wr(scx_pkg::REG_MODE, 8'h3C);
    k = rx_irqs;
    st.send({2'b10, d, 1'b0}, 11);
    chk_reg("wake irqs", 8'(k), 8'hFF, 8'(rx_irqs));
    rd(scx_pkg::REG_BUF, d, 8'hFF);
    st.send({2'b11, d2, 1'b0}, 11);
    chk_reg("wake irqs", 8'(k + 1), 8'hFF, 8'(rx_irqs));
    rd(scx_pkg::REG_CTRL, 8'h80, 8'h80);
    repeat (4) @(posedge clk_i);
    tally_and_finish();
  end
endmodule
